// ==== hdl/pipelined_sram_data_port.sv ====
/*
 Data-port side of a synchronous pipelined SRAM: pin capture, two-cycle read
 pipeline, output-enable steering, burst counter and sleep sequencing.
 Assumes access strobes come from same-clock logic; output enable, sleep and
 the burst-order strap are pins and are synchronised before use.
*/
`default_nettype none
`include "sram_port_cfg.svh"
// Contract
// R1 - Sleep request high puts device asleep, memory contents kept.
// R2 - Sleep low or undriven for normal use; undriven reads as low.
// R3 - Data and parity inputs are registered on every rising clock edge; the code registers them only on edges with clkEn high.
// R4 - Read data is the word addressed one clock edge earlier; the code drives it two clock edges after the address is taken.
// R5 - Output enable low drives data and parity lines.
// R6 - Output enable high releases data and parity lines to high impedance.
// R7 - Strap low selects linear burst order.
// R8 - Strap high or undriven selects interleaved burst order.
// R9 - Partner keeps the strap constant while the device operates.
// R10 - Two-bit wrapping burst counter loaded at start, stepped by burst step.
// R11 - Sleep entry and exit take two cycles; deselect before sleep.
// R12 - A detected write releases data lines regardless of output enable.
// R13 - Asleep, accesses are ignored and data lines stay released.
module pipelined_sram_data_port
   import sram_port_pkg::*;
#(
   parameter int DATA_W  = `SRAM_DATA_W,
   parameter int ADDR_W  = `SRAM_ADDR_W,
   parameter int SLEEP_C = `SRAM_SLEEP_CYC
) (
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire logic              clkEn,
   input  wire logic              accessStart,
   input  wire logic              writeCycle,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              burst_step_n,
   input  wire logic              outEnable_n,
   input  wire logic              sleep_request,
   input  wire logic              burstOrderStrap,
   input  wire logic [DATA_W-1:0] dataIn,
   output logic      [DATA_W-1:0] dataOut,
   output logic                   dataOe_n,
   output logic      [DATA_W-1:0] capturedData,
   output logic                   readValid,
   input  wire logic              readReady,
   output logic                   asleep
);
   localparam int BW = `SRAM_BURST_W;
   logic [DATA_W-1:0] mem [2**ADDR_W];
   logic [1:0]        oeSync;
   logic [1:0]        sleepSync;
   logic [1:0]        strapSync;
   logic              linearOrder;
   pwr_state_e        pwrState;
   pwr_state_e        next_pwrState;
   logic [1:0]        sleepCnt;
   logic [ADDR_W-1:0] baseAddr;
   logic [BW-1:0]     burstStart;
   logic [BW-1:0]     burstOffset;
   logic              burstActive;
   logic              burstWrite;
   logic              readPend;
   logic [DATA_W-1:0] readWord;
   logic              writePend;
   logic [ADDR_W-1:0] writeAddr;

   // The second stage is the only reader of each first stage.
   wire sleepLvl = sleepSync[1];
   wire oeLvl_n  = oeSync[1];
   wire awake    = (pwrState == PWR_AWAKE);
   // Interleaved order flips address bits; linear order adds with wrap.
   wire [BW-1:0] nextOffset = burstOffset + 2'h1;
   wire [BW-1:0] linAddr    = burstStart + nextOffset; // R7
   wire [BW-1:0] intAddr    = burstStart ^ nextOffset; // R8
   wire [BW-1:0] stepAddr   = linearOrder ? linAddr : intAddr;
   wire          doStart    = awake && accessStart; // R13
   wire          doStep     = awake && !accessStart && burstActive && !burst_step_n; // R10
   wire          isWrite    = doStart ? writeCycle : (doStep && burstWrite);
   wire [ADDR_W-1:0] curAddr = doStart ? address : {baseAddr[ADDR_W-1:BW], stepAddr};
   wire          readReq    = (doStart || doStep) && !isWrite;
   wire          bufReady;
   wire          bufValid;
   wire [DATA_W-1:0] bufData;
   wire          sleepDone  = (sleepCnt == 2'(SLEEP_C - 1));
   // R12 R13 R5 R6
   wire          next_oe_n  = oeLvl_n || !awake || isWrite || writePend || !bufValid;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         oeSync    <= 2'h3;
         sleepSync <= 2'h0; // R2
         strapSync <= 2'h3;
      end else if (clkEn) begin
         oeSync    <= {oeSync[0], outEnable_n};
         sleepSync <= {sleepSync[0], sleep_request};
         strapSync <= {strapSync[0], burstOrderStrap};
      end
   end

   // The strap is static, so following it every cycle only waits out the synchroniser.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         linearOrder <= 1'b0;
      end else if (clkEn) begin
         linearOrder <= !strapSync[1]; // R7 R8
      end
   end

   always_comb begin
      next_pwrState = pwrState;
      case (pwrState)
         PWR_AWAKE:    if (sleepLvl) next_pwrState = PWR_ENTERING; // R1
         PWR_ENTERING: if (sleepDone) next_pwrState = PWR_ASLEEP; // R11
         PWR_ASLEEP:   if (!sleepLvl) next_pwrState = PWR_LEAVING;
         PWR_LEAVING:  if (sleepDone) next_pwrState = PWR_AWAKE; // R11
         default:      next_pwrState = PWR_AWAKE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pwrState <= PWR_AWAKE;
         sleepCnt <= 2'h0;
         asleep   <= 1'b0;
      end else if (clkEn) begin
         pwrState <= next_pwrState;
         sleepCnt <= (next_pwrState != pwrState) ? 2'h0 : sleepCnt + 2'h1;
         asleep   <= (next_pwrState != PWR_AWAKE);
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         baseAddr    <= '0;
         burstStart  <= '0;
         burstOffset <= '0;
         burstActive <= 1'b0;
         burstWrite  <= 1'b0;
      end else if (clkEn) begin
         if (!awake) begin
            burstActive <= 1'b0; // R11
         end else if (doStart) begin
            baseAddr    <= address;
            burstStart  <= address[BW-1:0]; // R10
            burstOffset <= '0;
            burstActive <= 1'b1;
            burstWrite  <= writeCycle;
         end else if (doStep) begin
            burstOffset <= nextOffset; // R10
         end
      end
   end

   // Write data is on the pins one edge after its address is taken.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         capturedData <= '0;
         writePend    <= 1'b0;
         writeAddr    <= '0;
         readPend     <= 1'b0;
         dataOe_n     <= 1'b1;
         dataOut      <= '0;
      end else if (clkEn) begin
         capturedData <= dataIn; // R3
         writePend    <= awake && isWrite;
         writeAddr    <= curAddr;
         readPend     <= readReq && bufReady;
         dataOe_n     <= next_oe_n;
         dataOut      <= bufData;
      end
   end

   // Contents are kept across sleep: the array is never cleared.
   always_ff @(posedge sys_clk) begin
      if (clkEn && writePend && awake) mem[writeAddr] <= dataIn; // R1
      if (clkEn && readReq) readWord <= mem[curAddr]; // R4
   end

   logic bufPop;
   assign bufPop = readReady || !oeLvl_n;

   read_skid_buffer #(.WIDTH(DATA_W)) u_readBuf (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .clkEn    (clkEn),
      .flush    (!awake),
      .inValid  (readPend),
      .inReady  (bufReady),
      .inData   (readWord),
      .outValid (bufValid),
      .outReady (bufPop),
      .outData  (bufData)
   );

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) readValid <= 1'b0;
      else if (clkEn) readValid <= bufValid && awake;
   end

   sequence sleepSeen;
      clkEn && pwrState == PWR_AWAKE && sleepLvl;
   endsequence
   sequence threeEnabled;
      clkEn [*3];
   endsequence
   AST_SLEEP_ENTRY: assert property (@(posedge sys_clk) disable iff (reset) // R11
      sleepSeen ##1 threeEnabled |-> pwrState == PWR_ASLEEP)
      else $error("sleep entry did not take two cycles");
   AST_SLEEP_RELEASE: assert property (@(posedge sys_clk) disable iff (reset) // R13
      clkEn && !awake |=> dataOe_n)
      else $error("data lines driven while asleep");
   AST_WRITE_RELEASE: assert property (@(posedge sys_clk) disable iff (reset) // R12
      clkEn && isWrite |=> dataOe_n)
      else $error("data lines driven during write");
   AST_OE_HIGH: assert property (@(posedge sys_clk) disable iff (reset) // R6
      clkEn && oeLvl_n |=> dataOe_n)
      else $error("data lines driven with output enable high");
   AST_CAPTURE: assert property (@(posedge sys_clk) disable iff (reset) // R3
      clkEn |=> capturedData == $past(dataIn))
      else $error("input data not captured");
   AST_IGNORE_ASLEEP: assert property (@(posedge sys_clk) disable iff (reset) // R13
      clkEn && pwrState == PWR_ASLEEP |=> !writePend && !readPend)
      else $error("access taken while asleep");
   AST_BURST_LOAD: assert property (@(posedge sys_clk) disable iff (reset) // R10
      clkEn && doStart |=> burstStart == $past(address[BW-1:0]) && burstOffset == '0)
      else $error("burst counter not loaded");
   AST_BURST_WRAP: assert property (@(posedge sys_clk) disable iff (reset) // R7
      clkEn && doStep && linearOrder |-> stepAddr == BW'(burstStart + burstOffset + 2'h1))
      else $error("linear burst step wrong");
endmodule
`default_nettype wire

// ==== hdl/read_skid_buffer.sv ====
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock and an asynchronous active-high reset.
*/
`default_nettype none
module read_skid_buffer #(
   parameter int WIDTH = 36
) (
   input  wire logic             sys_clk,
   input  wire logic             reset,
   input  wire logic             clkEn,
   input  wire logic             flush,
   input  wire logic             inValid,
   output var  logic             inReady,
   input  wire logic [WIDTH-1:0] inData,
   output var  logic             outValid,
   input  wire logic             outReady,
   output var  logic [WIDTH-1:0] outData
);
   logic [WIDTH-1:0] slot [2];
   logic             wrPtr;
   logic             rdPtr;
   logic [1:0]       count;
   wire              doPush = inValid && inReady;
   wire              doPop  = outValid && outReady;

   assign inReady  = (count != 2'h2);
   assign outValid = (count != 2'h0);
   assign outData  = slot[rdPtr];

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wrPtr <= 1'b0;
         rdPtr <= 1'b0;
         count <= 2'h0;
      end else if (clkEn) begin
         if (flush) begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            count <= 2'h0;
         end else begin
            if (doPush) wrPtr <= ~wrPtr;
            if (doPop) rdPtr <= ~rdPtr;
            count <= count + {1'b0, doPush} - {1'b0, doPop};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (clkEn && doPush) slot[wrPtr] <= inData;
   end
endmodule
`default_nettype wire

// ==== hdl/sram_port_cfg.svh ====
/*
 Constants for the pipelined SRAM data port: widths, depths and sleep timing.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SRAM_PORT_CFG_SVH
`define SRAM_PORT_CFG_SVH
`define SRAM_DATA_W      36
`define SRAM_ADDR_W      10
`define SRAM_SLEEP_CYC   2
`define SRAM_BURST_W     2
`endif

// ==== hdl/sram_port_pkg.sv ====
/*
 Types shared by the pipelined SRAM data port.
 Assumes the constants header is on the include path.
*/
`default_nettype none
package sram_port_pkg;
   typedef enum logic [3:0] {
      PWR_AWAKE    = 4'h1,
      PWR_ENTERING = 4'h2,
      PWR_ASLEEP   = 4'h4,
      PWR_LEAVING  = 4'h8
   } pwr_state_e;
endpackage
`default_nettype wire

// ==== sim/pipelined_sram_data_port_test.sv ====
/*
 Self-checking bench for the pipelined SRAM data port.
 Assumes the host model resolves the shared data lines.
*/
`default_nettype none
module pipelined_sram_data_port_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, reset, accessStart, writeCycle, burst_step_n, outEnable_n;
   logic sleep_request, burstOrderStrap, hostDrive, readValid, asleep, dataOe_n;
   logic clkEn, readReady;
   logic [9:0] address;
   logic [35:0] dataIn, dataOut, capturedData, hostWord;
   int fails, totalChecks, cycles;
   pipelined_sram_data_port uut (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
      .accessStart(accessStart), .writeCycle(writeCycle), .address(address),
      .burst_step_n(burst_step_n), .outEnable_n(outEnable_n), .sleep_request(sleep_request),
      .burstOrderStrap(burstOrderStrap), .dataIn(dataIn), .dataOut(dataOut),
      .dataOe_n(dataOe_n), .capturedData(capturedData), .readValid(readValid),
      .readReady(readReady), .asleep(asleep));
   sram_host_model host (.sys_clk(sys_clk), .dataOut(dataOut), .dataOe_n(dataOe_n),
      .hostDrive(hostDrive), .hostWord(hostWord), .dataIn(dataIn));
   function automatic logic [35:0] word(input logic [9:0] a);
      return {8'ha5, 18'h0, a};
   endfunction
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", totalChecks, fails);
      if (fails == 0 && totalChecks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic do_reset(input logic mode);
      @(posedge sys_clk);
      reset <= 1'b1;
      burstOrderStrap <= mode;
      repeat (10) @(posedge sys_clk);
      check({dataOe_n, readValid, asleep}, 36'h4);
      reset <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [9:0] a);
      @(posedge sys_clk);
      accessStart <= 1'b1;
      writeCycle <= 1'b1;
      address <= a;
      @(posedge sys_clk);
      accessStart <= 1'b0;
      hostDrive <= 1'b1;
      hostWord <= word(a);
      @(posedge sys_clk);
      hostDrive <= 1'b0;
      #1;
      check(capturedData, word(a));
      check(dataOe_n, 36'h1);
   endtask
   // Every cycle with the lines driven is one delivered word.
   task automatic rd(input logic [9:0] a, input int steps, input int cnt);
      int n;
      logic [1:0] o;
      n = 0;
      @(posedge sys_clk);
      accessStart <= 1'b1;
      writeCycle <= 1'b0;
      address <= a;
      for (int i = 0; i < 14; i++) begin
         @(posedge sys_clk);
         accessStart <= 1'b0;
         burst_step_n <= !(i < steps);
         #1;
         if (dataOe_n === 1'b0) begin
            o = burstOrderStrap ? a[1:0] ^ n[1:0] : a[1:0] + n[1:0];
            check(dataOut, word({a[9:2], o}));
            check(readValid, 36'h1);
            n++;
         end
      end
      check(36'(n), 36'(cnt));
   endtask
   // A word held by a stalled reader waits through a frozen clock until the lines are enabled.
   task automatic stall_test();
      @(posedge sys_clk);
      outEnable_n <= 1'b1;
      readReady <= 1'b0;
      rd(10'h21, 0, 0);
      @(posedge sys_clk);
      clkEn <= 1'b0;
      outEnable_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      check({dataOe_n, readValid}, 36'h3);
      @(posedge sys_clk);
      clkEn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      check(dataOe_n, 36'h0);
      check(dataOut, word(10'h21));
      @(posedge sys_clk);
      readReady <= 1'b1;
   endtask
   task automatic sleep_test();
      @(posedge sys_clk);
      sleep_request <= 1'b1;
      for (int i = 0; i < 8 && asleep !== 1'b1; i++) @(posedge sys_clk);
      #1;
      check(asleep, 36'h1);
      rd(10'h20, 0, 0);
      @(posedge sys_clk);
      sleep_request <= 1'b0;
      repeat (8) @(posedge sys_clk);
      #1;
      check(asleep, 36'h0);
      rd(10'h22, 0, 1);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      {reset, clkEn, readReady, burst_step_n} = 4'hf;
      {accessStart, writeCycle, outEnable_n, sleep_request, hostDrive} = 5'h0;
      {burstOrderStrap, address, hostWord} = '0;
      for (int m = 0; m < 2; m++) begin
         do_reset(m[0]);
         for (int k = 0; k < 4; k++) wr(10'h20 + 10'(k));
         rd(10'h21, 3, 4);
         rd(10'h23, 0, 1);
      end
      stall_test();
      sleep_test();
      final_report();
   end
endmodule
`default_nettype wire

// ==== sim/sram_host_model.sv ====
/*
 Processor-side model of the shared data and parity lines.
 Assumes the bench supplies the write word and the drive request.
*/
`default_nettype none
module sram_host_model #(
   parameter int W = 36
) (
   input  wire logic         sys_clk,
   input  wire logic [W-1:0] dataOut,
   input  wire logic         dataOe_n,
   input  wire logic         hostDrive,
   input  wire logic [W-1:0] hostWord,
   output var  logic [W-1:0] dataIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [W-1:0] lastLevel = '0;
   always @(posedge sys_clk) begin
      lastLevel <= dataIn;
   end
   // Released lines have no keeper, so they show the inverse of the last level.
   assign dataIn = !dataOe_n ? dataOut : hostDrive ? hostWord : ~lastLevel;
endmodule
`default_nettype wire
